// >>> sclw_pkg.sv
// Constants and state types for the serial control word loader.
// Overview of operation
// - The device holds eight 40-bit control words, loaded only through the three-pin serial port.
// - Words are shifted most significant bit first, bit 39 first and bit 0 last.
// - Bits 39 to 37 of each word pick its address; addresses 1 to 7 each pick one of seven control buffers, address 0 has none.
// - Each word first lands in its addressed buffer, apart from the working register.
// - A word with bit 36 set copies every buffer to its working register once it is loaded.
// - A word with bit 36 clear changes only its buffer and leaves all working registers alone.
// - All buffers are copied to the working registers on the third rising clock edge after reset.
// - The address 0 word only triggers the update and is taken whatever the select level.
// - Address 000 is the broadcast word, whose bits 35 to 32 are reserved zeros.
// - Address 001 selects the phase generator, test enable and output configuration buffer.
package sclw_pkg;
  localparam int unsigned WORD_W    = 40;
  localparam int unsigned NUM_WORDS = 8;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned CNT_W     = 6;
  localparam int unsigned ADDR_HI   = 39;
  localparam int unsigned ADDR_LO   = 37;
  localparam int unsigned UPD_BIT   = 36;

  localparam logic [ADDR_W-1:0] ADDR_BROADCAST = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_TEST_OUT = 3'h1;

  localparam logic [CNT_W-1:0] BITS_PER_WORD = 6'h28;
  localparam logic [1:0] RESET_COPY_EDGE = 2'h2;
  localparam logic [1:0] RESET_DONE = 2'h3;
  localparam logic [WORD_W-1:0] WORD_RESET = 40'h00_0000_0000;

  typedef logic [NUM_WORDS-1:0][WORD_W-1:0] sclw_bank_t;

  typedef struct packed {
    logic [2:0]        sclk_sync;
    logic [1:0]        data_sync;
    logic [1:0]        sel_n_sync;
    logic              sel_n_last;
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0]  count;
    logic              sel_seen;
    logic [1:0]        rst_edges;
    logic              update;
    sclw_bank_t        buffers;
    sclw_bank_t        working;
  } sclw_state_s;
endpackage : sclw_pkg

// >>> sclw_loader.sv
// Serial control word loader: shift port, seven buffers and working registers.
`timescale 1ns/100ps
`default_nettype none
module sclw_loader (
  input  wire logic            clk_in,
  input  wire logic            sys_rst_in,
  input  wire logic            control_shift_clock_in,
  input  wire logic            control_data_in,
  input  wire logic            control_select_n_in,
  output logic [sclw_pkg::NUM_WORDS-1:0][sclw_pkg::WORD_W-1:0] working_regs_out,
  output logic                 update_pulse_out
);
  import sclw_pkg::*;

  // Synchronisers reset to the idle pin levels, so that no false select release follows reset.
  localparam sclw_state_s STATE_IDLE = '{
    sel_n_sync: 2'h3,
    sel_n_last: 1'b1,
    default:    '0
  };

  sclw_state_s s_q;
  sclw_state_s s_d;

  logic              clock_rise;
  logic              select_release;
  logic              select_now;
  logic              word_done;
  logic              word_taken;
  logic              copy_on_reset;
  logic [WORD_W-1:0] word;
  logic [ADDR_W-1:0] addr;

  // Moves a pin one stage further down a two-stage synchroniser.
  function automatic logic [1:0] sclw_sync2(
    input logic [1:0] stages,
    input logic       pin
  );
    sclw_sync2 = {stages[0], pin};
  endfunction : sclw_sync2

  // The shift clock keeps one stage more than the data pin, for edge finding; select gets its extra stage in sel_n_last.
  function automatic logic [2:0] sclw_sync3(
    input logic [2:0] stages,
    input logic       pin
  );
    sclw_sync3 = {stages[1:0], pin};
  endfunction : sclw_sync3

  // A level that is high now and was low one clock earlier marks a rising edge.
  function automatic logic sclw_rose(
    input logic now_level,
    input logic last_level
  );
    sclw_rose = now_level & ~last_level;
  endfunction : sclw_rose

  // Select is active low.
  function automatic logic sclw_selected(
    input logic sel_n
  );
    sclw_selected = ~sel_n;
  endfunction : sclw_selected

  // The newest bit enters at the bottom, so the first bit shifted ends up at the top.
  function automatic logic [WORD_W-1:0] sclw_shift_in(
    input logic [WORD_W-1:0] shift,
    input logic              data_bit
  );
    sclw_shift_in = {shift[WORD_W-2:0], data_bit};
  endfunction : sclw_shift_in

  function automatic logic [ADDR_W-1:0] sclw_addr_of(
    input logic [WORD_W-1:0] w
  );
    sclw_addr_of = w[ADDR_HI:ADDR_LO];
  endfunction : sclw_addr_of

  function automatic logic sclw_wants_update(
    input logic [WORD_W-1:0] w
  );
    sclw_wants_update = w[UPD_BIT];
  endfunction : sclw_wants_update

  function automatic logic sclw_last_bit(
    input logic [CNT_W-1:0] count
  );
    sclw_last_bit = (count == BITS_PER_WORD - 6'h1);
  endfunction : sclw_last_bit

  function automatic logic [CNT_W-1:0] sclw_count_next(
    input logic [CNT_W-1:0] count
  );
    if (sclw_last_bit(count)) begin
      sclw_count_next = '0;
    end else begin
      sclw_count_next = count + 6'h1;
    end
  endfunction : sclw_count_next

  // The last bit only completes a word when no select release restarts the framing.
  function automatic logic sclw_word_done(
    input logic             rise,
    input logic [CNT_W-1:0] count,
    input logic             restart
  );
    sclw_word_done = rise & sclw_last_bit(count) & ~restart;
  endfunction : sclw_word_done

  // Select counts as seen once it is low at any shift edge of the word.
  function automatic logic sclw_sel_next(
    input logic seen,
    input logic selected,
    input logic done
  );
    sclw_sel_next = (seen | selected) & ~done;
  endfunction : sclw_sel_next

  // Address 0 is taken whatever the select level; every other word needs select seen low.
  function automatic logic sclw_accepts(
    input logic [ADDR_W-1:0] a,
    input logic              sel_seen,
    input logic              selected
  );
    sclw_accepts = (a == ADDR_BROADCAST) || sel_seen || selected;
  endfunction : sclw_accepts

  // Writes one buffer; the broadcast address has no storage behind it.
  function automatic sclw_bank_t sclw_store(
    input sclw_bank_t        bank,
    input logic [ADDR_W-1:0] a,
    input logic [WORD_W-1:0] w
  );
    sclw_store = bank;
    for (int unsigned i = 1; i < NUM_WORDS; i++) begin
      if (a == i[ADDR_W-1:0]) begin
        sclw_store[i] = w;
      end
    end
  endfunction : sclw_store

  // Copies every buffer at once; slot 0 always reads back as the reset word.
  function automatic sclw_bank_t sclw_copy_all(
    input sclw_bank_t bank
  );
    sclw_copy_all                 = bank;
    sclw_copy_all[ADDR_BROADCAST] = WORD_RESET;
  endfunction : sclw_copy_all

  function automatic logic [1:0] sclw_reset_step(
    input logic [1:0] edges
  );
    if (edges == RESET_DONE) begin
      sclw_reset_step = edges;
    end else begin
      sclw_reset_step = edges + 2'h1;
    end
  endfunction : sclw_reset_step

  function automatic logic sclw_reset_copy_due(
    input logic [1:0] edges
  );
    sclw_reset_copy_due = (edges == RESET_COPY_EDGE);
  endfunction : sclw_reset_copy_due

  always_comb begin
    s_d        = s_q;
    s_d.update = 1'b0;

    // Pins pass two flip-flops before any logic reads them.
    s_d.sclk_sync  = sclw_sync3(s_q.sclk_sync, control_shift_clock_in);
    s_d.data_sync  = sclw_sync2(s_q.data_sync, control_data_in);
    s_d.sel_n_sync = sclw_sync2(s_q.sel_n_sync, control_select_n_in);
    s_d.sel_n_last = s_q.sel_n_sync[1];

    clock_rise     = sclw_rose(s_q.sclk_sync[1], s_q.sclk_sync[2]);
    select_release = sclw_rose(s_q.sel_n_sync[1], s_q.sel_n_last);
    select_now     = sclw_selected(s_q.sel_n_sync[1]);
    word           = sclw_shift_in(s_q.shift, s_q.data_sync[1]);
    addr           = sclw_addr_of(word);
    word_done      = sclw_word_done(clock_rise, s_q.count, select_release);
    word_taken     = word_done & sclw_accepts(addr, s_q.sel_seen, select_now);
    copy_on_reset  = sclw_reset_copy_due(s_q.rst_edges);

    s_d.rst_edges = sclw_reset_step(s_q.rst_edges);
    if (copy_on_reset) begin
      s_d.working = sclw_copy_all(s_q.buffers);
      s_d.update  = 1'b1;
    end

    // A select release restarts the framing even in mid word.
    if (select_release) begin
      s_d.count    = '0;
      s_d.sel_seen = 1'b0;
    end else if (clock_rise) begin
      s_d.shift    = word;
      s_d.count    = sclw_count_next(s_q.count);
      s_d.sel_seen = sclw_sel_next(s_q.sel_seen, select_now, word_done);
    end

    if (word_taken) begin
      s_d.buffers = sclw_store(s_q.buffers, addr, word);
      // The copy sees the buffers as they stand after this word lands.
      if (sclw_wants_update(word)) begin
        s_d.working = sclw_copy_all(s_d.buffers);
        s_d.update  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= STATE_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign working_regs_out = s_q.working;
  assign update_pulse_out = s_q.update;
endmodule : sclw_loader
`default_nettype wire

// >>> sclw_loader_props.sv
// Assertions on the control word loader ports.
`timescale 1ns/100ps
`default_nettype none
module sclw_loader_props (input wire logic clk_in, sys_rst_in, control_shift_clock_in,
  control_select_n_in, update_pulse_out, input wire sclw_pkg::sclw_bank_t working_regs_out);
  wire logic                 p = update_pulse_out;
  wire sclw_pkg::sclw_bank_t w = working_regs_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_word0_empty: assert property (w[0] == '0) else $error("word 0 kept");
  a_silent_change: assert property ($changed(w) |-> p) else $error("silent change");
  a_pulse_single: assert property (p |=> !p) else $error("long pulse");
  a_pulse_settled: assert property (p |=> $stable(w)) else $error("late change");
  a_reset_copy: assert property ($fell(sys_rst_in) |-> (!p)[*3] ##1 p) else $error("copy edge");
  a_reset_empty: assert property ($fell(sys_rst_in) |-> w == '0) else $error("not empty");
  a_idle_quiet: assert property ((!control_shift_clock_in)[*8] |-> !p) else $error("idle");
  a_rise_gap: assert property ($rose(control_shift_clock_in) |-> (!p)[*2]) else $error("early");
  cover property ($fell(sys_rst_in) ##3 p);
  cover property (p && w[1] != '0);
  cover property (p && control_select_n_in);
endmodule : sclw_loader_props
bind sclw_loader sclw_loader_props i_sclw_loader_props (.*);
`default_nettype wire

// >>> sclw_host.sv
// Host serial port model that shifts whole control words.
`timescale 1ns/100ps
`default_nettype none
module sclw_host (input wire logic clk_in, output var logic sck_out, dat_out, sel_n_out);
  initial {sck_out, dat_out, sel_n_out} = 3'h1;
  task automatic send(input logic [39:0] w, input logic s);
    @(posedge clk_in) sel_n_out <= !s;
    for (int n = 0; n < 320; n++) @(posedge clk_in)
      {sck_out, dat_out} <= {n % 8 inside {[3:6]}, w[39 - n / 8]};
    repeat (4) @(posedge clk_in);
    {sel_n_out, dat_out} <= {1'b1, !w[0]};
  endtask : send
endmodule : sclw_host
`default_nettype wire

// >>> sclw_loader_tb.sv
// Self-checking bench for the control word loader.
`timescale 1ns/100ps
`default_nettype none
module sclw_loader_tb;
  logic                 clk_in = 0, rst = 1, sck, dat, seln, up;
  sclw_pkg::sclw_bank_t wr, b = '0;
  int                   mismatches = 0, checks = 0, pulses = 0;
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) pulses <= pulses + int'(up === 1'b1);
  sclw_loader i_sclw_loader (.clk_in, .sys_rst_in(rst), .control_shift_clock_in(sck),
    .control_data_in(dat), .control_select_n_in(seln), .working_regs_out(wr), .update_pulse_out(up));
  sclw_host i_sclw_host (.clk_in, .sck_out(sck), .dat_out(dat), .sel_n_out(seln));
  task automatic chk(input string name, input sclw_pkg::sclw_bank_t got, exp);
    checks++;
    if (got !== exp) $display("[ERR] %s exp %h got %h", name, exp, got);
    mismatches += int'(got !== exp);
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (!mismatches && checks) $display("Run complete: PASS"); else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (3) @(posedge clk_in);
    rst <= 0;
    for (int a = 1; a < 8; a++) begin
      b[a] = {3'(a), 1'b0, 36'(a) * 36'h1_1111_1111};
      i_sclw_host.send(b[a], 1);
    end
    chk("working_regs", wr, '0);
    chk("update_pulses", pulses, 1);
    i_sclw_host.send(40'h50_0000_0005, 0);
    i_sclw_host.send(40'h10_0000_0000, 0);
    chk("working_regs", wr, b);
    b[3] = 40'h70_0000_0033;
    i_sclw_host.send(b[3], 1);
    chk("working_regs", wr, b);
    chk("update_pulses", pulses, 3);
    close_out;
  end
endmodule : sclw_loader_tb
`default_nettype wire
